/* design/i2c_cfg_pkg.sv */
// Package: register map, field layout, reset values and timing constants
//
// Operation
// RQ1 - Target address comes from field; zero means address 0x08, else used as-is.
// RQ2 - Short-low enable times out the interface when SCL stays low about 25 ms.
// RQ3 - Short-high enable times out the interface when SCL stays high too long.
// RQ4 - Short-high duration codes: 0=64 ms, 1=512 ms, 2=1 ms, 3=15 ms.
// RQ5 - Long-low condition bit: clear watches SCL low, set watches SCL and SDA low.
// RQ6 - Long-low duration code 0 disables; codes 1-7 give code times 0.5 s.
// RQ7 - Long-low duration resets to code 4, active at 2 s.
// RQ8 - Short-high duration resets to code 3, 15 ms.
// RQ9 - Bus-busy enable times out a transaction longer than the long-low duration.
// RQ10 - CRC enable bit selects CRC on transfers for both ends; default off.
// RQ11 - Config word resets to 0x3400; address resets to 0x08, top bit reserved.
// RQ12 - Any enabled timeout abandons the transfer, releases SDA, returns to idle.
// RQ13 - Bus controller keeps phases and transactions shorter than enabled timeouts.
`default_nettype none
package i2c_cfg_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] REG_ADDR = 2'h0;
   localparam logic [1:0] REG_CFG = 2'h1;
   localparam logic [1:0] REG_STAT = 2'h2;
   // Reset values
   localparam logic [7:0] ADDR_RST = 8'h08;
   localparam logic [15:0] CFG_RST = 16'h3400;
   localparam logic [6:0] ADDR_ZERO_MAP = 7'h08;
   // Writable bits of each register, reserved bits read zero
   localparam logic [7:0] ADDR_MASK = 8'h7f;
   localparam logic [15:0] CFG_MASK = 16'hff03;
   // Config field positions
   localparam int CFG_SL_EN = 15;
   localparam int CFG_SH_EN = 14;
   localparam int CFG_SH_SEL = 12;
   localparam int CFG_LL_COND = 11;
   localparam int CFG_LL_SEL = 8;
   localparam int CFG_BB_EN = 1;
   localparam int CFG_CRC_EN = 0;
   // Time base: one tick every TICK_US microseconds
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 500;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   // Timeout durations in their own units
   localparam int SL_MS = 25;
   localparam int SH0_MS = 64;
   localparam int SH1_MS = 512;
   localparam int SH2_MS = 1;
   localparam int SH3_MS = 15;
   localparam int LL_STEP_MS = 500;
   // The same durations in ticks
   localparam int TO_W = 13;
   localparam logic [TO_W-1:0] SL_TICKS = TO_W'(SL_MS * 1000 / TICK_US);
   localparam logic [TO_W-1:0] SH0_TICKS = TO_W'(SH0_MS * 1000 / TICK_US);
   localparam logic [TO_W-1:0] SH1_TICKS = TO_W'(SH1_MS * 1000 / TICK_US);
   localparam logic [TO_W-1:0] SH2_TICKS = TO_W'(SH2_MS * 1000 / TICK_US);
   localparam logic [TO_W-1:0] SH3_TICKS = TO_W'(SH3_MS * 1000 / TICK_US);
   localparam logic [TO_W-1:0] LL_STEP_TICKS = TO_W'(LL_STEP_MS * 1000 / TICK_US);
   // Timer slots
   localparam int N_TO = 4;
   localparam int TO_SL = 0;
   localparam int TO_SH = 1;
   localparam int TO_LL = 2;
   localparam int TO_BB = 3;
   // Serial interface states, Gray along idle-addr-ack-hold
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_ACK = 2'b11,
      ST_HOLD = 2'b10
   } if_state_t;
endpackage
`default_nettype wire

/* design/bus_timeout_timer.sv */
// Tick-based timeout timer: expires when its condition holds for limit ticks
`default_nettype none
module bus_timeout_timer #(
   parameter int W = 13
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic tick_i,
   input wire logic en_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   output logic expired_o
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic exp_q;
   logic exp_d;

   // Count ticks while enabled and condition holds, restart otherwise
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (!en_i || !run_i) begin
         cnt_d = '0;
      end else begin
         if (tick_i && (cnt_q < limit_i)) begin
            cnt_d = cnt_q + W'(1);
         end
         exp_d = (cnt_q >= limit_i);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired_o = exp_q;
endmodule
`default_nettype wire

/* design/i2c_target_addr_timeout_cfg.sv */
// I2C target front end with address, watchdog timeouts and CRC configuration
`default_nettype none
module i2c_target_addr_timeout_cfg
   import i2c_cfg_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [1:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [15:0] reg_rdata_o,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Status to the rest of the device
   output logic [6:0] target_addr_o,
   output logic crc_en_o,
   output logic selected_o,
   output logic timeout_o
);
   localparam int DIV_W = 32;

   // Effective address: zero selects the fixed default
   function automatic logic [6:0] eff_addr(input logic [6:0] field);
      eff_addr = (field == 7'h00) ? ADDR_ZERO_MAP : field; // [RQ1]
   endfunction

   // Short-high duration decode to ticks
   function automatic logic [TO_W-1:0] sh_limit(input logic [1:0] code);
      case (code)
         2'h0: sh_limit = SH0_TICKS; // [RQ4]
         2'h1: sh_limit = SH1_TICKS;
         2'h2: sh_limit = SH2_TICKS;
         default: sh_limit = SH3_TICKS;
      endcase
   endfunction

   // Registers
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic [N_TO-1:0] cause_q;
   logic [N_TO-1:0] cause_d;
   // Synchronisers and edge history
   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   // Time base
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic tick_q;
   logic tick_d;
   // Serial interface
   if_state_t st_q;
   if_state_t st_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic busy_q;
   logic busy_d;
   logic oe_q;
   logic oe_d;
   logic sel_q;
   logic sel_d;
   logic to_q;
   logic to_d;
   logic [N_TO-1:0] exp_prev_q;
   // Timers
   logic [N_TO-1:0] to_en;
   logic [N_TO-1:0] to_run;
   logic [TO_W-1:0] to_lim [N_TO];
   logic [N_TO-1:0] expired;
   logic abort;
   logic start_c;
   logic stop_c;
   logic scl_rise;
   logic scl_fall;
   logic [2:0] ll_code;

   // Two-stage synchronisers on both pins, then one history stage
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // Bus conditions from synchronised levels
   assign start_c = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign stop_c = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign scl_rise = scl_s_q && !scl_p_q;
   assign scl_fall = !scl_s_q && scl_p_q;

   // Tick divider for all timeout timers
   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + DIV_W'(1);
      if (div_q >= DIV_W'(TICK_CYCLES - 1)) begin
         div_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   // Timer enables, conditions and limits
   assign ll_code = cfg_q[CFG_LL_SEL +: 3];
   always_comb begin
      to_en[TO_SL] = cfg_q[CFG_SL_EN]; // [RQ2]
      to_run[TO_SL] = !scl_s_q;
      to_lim[TO_SL] = SL_TICKS;
      to_en[TO_SH] = cfg_q[CFG_SH_EN]; // [RQ3]
      to_run[TO_SH] = scl_s_q && busy_q;
      to_lim[TO_SH] = sh_limit(cfg_q[CFG_SH_SEL +: 2]);
      to_en[TO_LL] = (ll_code != 3'h0); // [RQ6]
      to_run[TO_LL] = cfg_q[CFG_LL_COND] ? (!scl_s_q && !sda_s_q) : !scl_s_q; // [RQ5]
      to_lim[TO_LL] = TO_W'(ll_code) * LL_STEP_TICKS; // [RQ6]
      to_en[TO_BB] = cfg_q[CFG_BB_EN] && (ll_code != 3'h0); // [RQ9]
      to_run[TO_BB] = busy_q;
      to_lim[TO_BB] = TO_W'(ll_code) * LL_STEP_TICKS; // [RQ9]
   end

   // One timer per watchdog
   genvar gi;
   generate
      for (gi = 0; gi < N_TO; gi++) begin : g_to
         bus_timeout_timer #(
            .W(TO_W)
         ) u_timer (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .tick_i(tick_q),
            .en_i(to_en[gi]),
            .run_i(to_run[gi]),
            .limit_i(to_lim[gi]),
            .expired_o(expired[gi])
         );
      end
   endgenerate

   // Any expiring timer aborts the interface
   assign abort = |expired;

   // Interface state machine: start, address byte, ack, hold until stop
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      busy_d = busy_q;
      oe_d = oe_q;
      sel_d = sel_q;
      if (abort) begin
         st_d = ST_IDLE; // [RQ12]
         busy_d = 1'b0;
         oe_d = 1'b0;
         sel_d = 1'b0;
         bit_d = '0;
      end else if (start_c) begin
         st_d = ST_ADDR;
         busy_d = 1'b1;
         oe_d = 1'b0;
         sel_d = 1'b0;
         bit_d = '0;
      end else if (stop_c) begin
         st_d = ST_IDLE;
         busy_d = 1'b0;
         oe_d = 1'b0;
         sel_d = 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s_q};
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall && (bit_q == 4'h8)) begin
                  if (sh_q[7:1] == eff_addr(addr_q[6:0])) begin // [RQ1]
                     st_d = ST_ACK;
                     oe_d = 1'b1;
                     sel_d = 1'b1;
                  end else begin
                     st_d = ST_HOLD;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  st_d = ST_HOLD;
                  oe_d = 1'b0;
               end
            end
            ST_HOLD: begin
               oe_d = 1'b0;
            end
            default: begin
               st_d = ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= ST_IDLE;
         sh_q <= '0;
         bit_q <= '0;
         busy_q <= 1'b0;
         oe_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         busy_q <= busy_d;
         oe_q <= oe_d;
         sel_q <= sel_d;
      end
   end

   // Timeout pulse on a new expiry; cause bits set wins over clear at start
   always_comb begin
      to_d = |(expired & ~exp_prev_q);
      cause_d = cause_q;
      if (start_c) begin
         cause_d = '0;
      end
      cause_d = cause_d | (expired & ~exp_prev_q);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         exp_prev_q <= '0;
         to_q <= 1'b0;
         cause_q <= '0;
      end else begin
         exp_prev_q <= expired;
         to_q <= to_d;
         cause_q <= cause_d;
      end
   end

   // Register writes and read data, one cycle after the read strobe
   always_comb begin
      addr_d = addr_q;
      cfg_d = cfg_q;
      rdata_d = '0;
      if (reg_we_i) begin
         case (reg_addr_i)
            REG_ADDR: addr_d = reg_wdata_i[7:0] & ADDR_MASK; // [RQ11]
            REG_CFG: cfg_d = reg_wdata_i & CFG_MASK;
            default: begin
            end
         endcase
      end
      if (reg_re_i) begin
         case (reg_addr_i)
            REG_ADDR: rdata_d = {8'h00, addr_q};
            REG_CFG: rdata_d = cfg_q;
            REG_STAT: rdata_d = {8'h00, st_q, sel_q, busy_q, cause_q};
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_q <= ADDR_RST; // [RQ11]
         cfg_q <= CFG_RST; // [RQ7] [RQ8] [RQ11]
         rdata_q <= '0;
      end else begin
         addr_q <= addr_d;
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
      end
   end

   // Output stage, all registered
   logic [6:0] taddr_q;
   logic crc_q;
   logic sda_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         taddr_q <= ADDR_ZERO_MAP;
         crc_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         taddr_q <= eff_addr(addr_q[6:0]); // [RQ1]
         crc_q <= cfg_q[CFG_CRC_EN]; // [RQ10]
         sda_q <= 1'b0;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign sda_o = sda_q;
   assign sda_oe_o = oe_q;
   assign target_addr_o = taddr_q;
   assign crc_en_o = crc_q;
   assign selected_o = sel_q;
   assign timeout_o = to_q;
endmodule
`default_nettype wire

/* tb/i2c_cfg_props.sv */
// Checker: port-level properties of the target address and watchdog block
`default_nettype none
module i2c_cfg_props
   import i2c_cfg_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [6:0] target_addr_o,
   input wire logic crc_en_o,
   input wire logic selected_o,
   input wire logic timeout_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // The first tick may land just after SCL falls, so expiry can come one tick early
   localparam int SL_LO = 49 * TICK_CYCLES;
   localparam int SL_HI = 51 * TICK_CYCLES + 8;
   logic [15:0] cfg_q, cfg_d, rexp;
   logic [7:0] adr_q, adr_d;
   logic [19:0] low_q, low_d;
   logic hit_q, hit_d;
   logic [6:0] tgt;
   // Shadow registers, expected read data and SCL low counter
   always_comb begin
      cfg_d = cfg_q;
      adr_d = adr_q;
      if (reg_we_i && reg_addr_i == REG_CFG) cfg_d = reg_wdata_i & 16'hff03;
      if (reg_we_i && reg_addr_i == REG_ADDR) adr_d = reg_wdata_i[7:0] & 8'h7f;
      low_d = scl_i ? 20'h0 : low_q + 20'h1;
      hit_d = scl_i ? 1'b0 : (hit_q | timeout_o);
      rexp = (reg_addr_i == REG_ADDR) ? {8'h00, adr_q} : (reg_addr_i == REG_CFG) ? cfg_q : 16'h0;
      tgt = (adr_q[6:0] == 7'h00) ? 7'h08 : adr_q[6:0];
   end
   // Register the shadow state
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_q <= 16'h3400;
         adr_q <= 8'h08;
         low_q <= 20'h0;
         hit_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         adr_q <= adr_d;
         low_q <= low_d;
         hit_q <= hit_d;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   chk_read_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside read slot");
   chk_read_value: assert property (reg_re_i && reg_addr_i != REG_STAT
      |=> reg_rdata_o == $past(rexp))
      else $error("read data differs from register contents");
   chk_target_map: assert property (target_addr_o == $past(tgt))
      else $error("effective address wrong");
   chk_crc_follow: assert property (crc_en_o == $past(cfg_q[0]))
      else $error("crc enable does not follow register");
   chk_ack_owner: assert property (sda_oe_o |-> !sda_o && selected_o)
      else $error("sda driven without selection");
   chk_to_pulse: assert property (timeout_o |=> !timeout_o)
      else $error("timeout pulse longer than one cycle");
   chk_to_abort: assert property (timeout_o |-> ##[0:1] (!sda_oe_o && !selected_o))
      else $error("transfer not abandoned on timeout");
   chk_sl_late: assert property (cfg_q[15] && low_q == 20'(SL_HI) |-> hit_q || timeout_o)
      else $error("short low timeout missing");
   chk_sl_early: assert property (timeout_o && cfg_q[15:14] == 2'b10
      && cfg_q[10:8] == 3'h0 && !cfg_q[1] |-> low_q >= 20'(SL_LO))
      else $error("short low timeout too early");
   chk_none_en: assert property (cfg_q[15:14] == 2'b00 && cfg_q[10:8] == 3'h0
      |-> !timeout_o)
      else $error("timeout while all timers off");
   cov_timeout: cover property (timeout_o);
   cov_ack: cover property ($rose(sda_oe_o));
   cov_crc: cover property (crc_en_o && reg_re_i);
endmodule
`default_nettype wire

/* tb/i2c_host_model.sv */
// Bus controller model: open-drain SCL and SDA with 160 ns bit time
`default_nettype none
module i2c_host_model (
   output var logic scl_o,
   output var logic sda_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus: both lines released
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Set both lines, 1 releases the line to the pull-up
   task automatic drive(input logic c, input logic d);
      scl_o = c;
      sda_o = d;
   endtask
   // One bit, data changed only while SCL low, phases far below any timeout
   task automatic bit_io(input logic d, output logic q);
      sda_o = d;
      #40 scl_o = 1'b1;
      #40 q = sda_i;
      #40 scl_o = 1'b0;
      #40;
   endtask
   // START: SDA falls while SCL high
   task automatic start();
      // Step off the clock edge so pins never change as the block samples them
      #2;
      drive(1'b1, 1'b1);
      #80 sda_o = 1'b0;
      #80 scl_o = 1'b0;
      #40;
   endtask
   // STOP: SDA rises while SCL high
   task automatic stop();
      drive(1'b0, 1'b0);
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b1;
      #80;
   endtask
   // Address byte MSB first plus acknowledge clock; no CRC byte follows
   task automatic send(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) bit_io(b[i], q);
      bit_io(1'b1, q);
      ack = ~q;
   endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench: register access, address match and watchdog timeouts
`default_nettype none
module tb_top
   import i2c_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 10;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic [6:0] target_addr_o;
   logic scl, host_sda, sda_o, sda_oe_o, crc_en_o, selected_o, timeout_o, ack;
   wire logic sda_w;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   // Wired-AND SDA with pull-up
   assign sda_w = host_sda & ~(sda_oe_o & ~sda_o);
   always #5 clk_i = ~clk_i;
   i2c_target_addr_timeout_cfg #(.TICK_CYCLES(TK)) u_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
      .reg_rdata_o(reg_rdata_o), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .target_addr_o(target_addr_o), .crc_en_o(crc_en_o),
      .selected_o(selected_o), .timeout_o(timeout_o));
   i2c_host_model u_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));
   // Cycle ceiling against a hang
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic chk_rd(input logic [1:0] a, input logic [15:0] exp, input string nm);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 cmp(nm, exp, reg_rdata_o);
   endtask
   // Wait for a timeout pulse and judge whether it fell in [lo, hi] cycles
   task automatic wait_to(input int lo, input int hi, input logic exp, input string nm);
      int n;
      n = 0;
      while (timeout_o !== 1'b1 && n <= hi) begin
         @(posedge clk_i);
         #1 n = n + 1;
      end
      cmp(nm, {15'h0, exp}, {15'h0, (n >= lo && n <= hi)});
   endtask
   task automatic t_regs();
      chk_rd(REG_ADDR, 16'h0008, "addr reset");
      chk_rd(REG_CFG, 16'h3400, "cfg reset");
      wr(2'h3, 16'hffff);
      chk_rd(2'h3, 16'h0000, "unmapped");
      chk_rd(REG_CFG, 16'h3400, "cfg kept");
      wr(REG_CFG, 16'h00ff);
      chk_rd(REG_CFG, 16'h0003, "cfg reserved");
      cmp("crc on", 16'h0001, {15'h0, crc_en_o});
      wr(REG_CFG, 16'h3400);
      chk_rd(REG_ADDR, 16'h0008, "addr kept");
      cmp("crc off", 16'h0000, {15'h0, crc_en_o});
   endtask
   task automatic t_match();
      logic [15:0] fld [3] = '{16'h00d5, 16'h0055, 16'h0000};
      logic [7:0] byt [3] = '{8'haa, 8'h24, 8'h10};
      logic [6:0] tg [3] = '{7'h55, 7'h55, 7'h08};
      logic [15:0] ok [3] = '{16'h1, 16'h0, 16'h1};
      for (int i = 0; i < 3; i++) begin
         wr(REG_ADDR, fld[i]);
         chk_rd(REG_ADDR, fld[i] & 16'h007f, "addr field");
         cmp("target", {9'h0, tg[i]}, {9'h0, target_addr_o});
         u_host.start();
         u_host.send(byt[i], ack);
         cmp("ack", ok[i], {15'h0, ack});
         cmp("selected", ok[i], {15'h0, selected_o});
         u_host.stop();
      end
   endtask
   task automatic t_short_low();
      wr(REG_CFG, 16'h8000);
      u_host.start();
      u_host.send(8'h10, ack);
      u_host.drive(1'b0, 1'b1);
      wait_to(50 * TK - 10, 51 * TK + 20, 1'b1, "short low");
      chk_rd(REG_STAT, 16'h0001, "cause short low");
      cmp("released", 16'h0, {14'h0, selected_o, sda_oe_o});
      u_host.stop();
   endtask
   task automatic t_short_high();
      int tk [4] = '{128, 1024, 2, 30};
      for (int c = 0; c < 4; c++) begin
         wr(REG_CFG, {2'b01, c[1:0], 12'h000});
         u_host.start();
         u_host.drive(1'b1, 1'b0);
         wait_to(tk[c] * TK - 5, tk[c] * TK + 30, 1'b1, "short high");
         chk_rd(REG_STAT, 16'h0002, "cause short high");
         u_host.stop();
      end
   endtask
   task automatic t_long_low();
      wr(REG_CFG, 16'h0900);
      u_host.start();
      u_host.drive(1'b0, 1'b1);
      wait_to(0, 1000 * TK + 100, 1'b0, "long low sda high");
      u_host.drive(1'b0, 1'b0);
      wait_to(1000 * TK - 5, 1001 * TK + 20, 1'b1, "long low both");
      chk_rd(REG_STAT, 16'h0004, "cause long low");
      u_host.stop();
      wr(REG_CFG, 16'h0100);
      u_host.start();
      u_host.drive(1'b0, 1'b1);
      wait_to(1000 * TK - 10, 1001 * TK + 20, 1'b1, "long low scl");
      u_host.stop();
   endtask
   task automatic t_bus_busy();
      wr(REG_CFG, 16'h0102);
      u_host.start();
      u_host.drive(1'b1, 1'b0);
      wait_to(1000 * TK - 20, 1001 * TK + 20, 1'b1, "bus busy");
      chk_rd(REG_STAT, 16'h0008, "cause bus busy");
      u_host.stop();
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_match();
      t_short_low();
      t_short_high();
      t_long_low();
      t_bus_busy();
      end_of_test();
   end
endmodule
bind i2c_target_addr_timeout_cfg i2c_cfg_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
   .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .target_addr_o(target_addr_o), .crc_en_o(crc_en_o), .selected_o(selected_o),
   .timeout_o(timeout_o));
`default_nettype wire
